// file: logic/pwo_defines.svh
// Register offsets, field positions and reset values of the override block.
// Assumes the includer sees it once per compile unit.
`ifndef PWO_DEFINES_SVH
`define PWO_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PWO_ADDR_TBCTL  8'h00
`define PWO_ADDR_PER    8'h04
`define PWO_ADDR_DUTY   8'h08
`define PWO_ADDR_PHASE  8'h0C
`define PWO_ADDR_DEAD   8'h10
`define PWO_ADDR_GEN    8'h14
`define PWO_ADDR_OUT    8'h18
`define PWO_ADDR_STAT   8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define PWO_TIME_LSB    3
`define PWO_TB_RUN      15
`define PWO_TB_HALT     13
`define PWO_GEN_MODE    0
`define PWO_GEN_IUE     2
`define PWO_GEN_LIMEN   3
`define PWO_GEN_CRST    4
`define PWO_GEN_TRIPEN  5
`define PWO_OUT_OWNH    15
`define PWO_OUT_OWNL    14
`define PWO_OUT_FENH    9
`define PWO_OUT_FENL    8
`define PWO_OUT_FVAL    6
`define PWO_OUT_TRIPD   4
`define PWO_OUT_LIMD    2
`define PWO_OUT_ALIGN   0

// ****************************************************************
// Reset values
// ****************************************************************
`define PWO_PER_RST     16'hFFF0

`endif

// file: logic/pwo_pkg.sv
// Types shared by the override block and its dead-time unit.
// Assumes nothing of its surroundings.
package pwo_pkg;
    // Output pairing modes
    typedef enum logic [1:0] {
        PWO_COMP = 2'b00,
        PWO_PUSH = 2'b01,
        PWO_VPH  = 2'b10
    } pwo_mode_t;

    // Time value, bit 0 here is register bit 3
    typedef logic [12:0] pwo_time_t;

    // Whole state of the top module
    typedef struct packed {
        logic       run;
        logic       halt_idle;
        pwo_time_t  per;
        pwo_time_t  duty_sh;
        pwo_time_t  duty;
        pwo_time_t  phase;
        pwo_time_t  dead;
        pwo_mode_t  mode;
        logic       instant_duty_update_en;
        logic       lim_en;
        logic       crst_en;
        logic       trip_en;
        logic [1:0] own;
        logic [1:0] limd;
        logic [1:0] tripd;
        logic [1:0] fen_p;
        logic [1:0] fval_p;
        logic [1:0] fen;
        logic [1:0] fval;
        logic       align;
        pwo_time_t  cnt;
        logic       pp;
        logic       cut;
        logic [1:0] req;
        logic [1:0] oe;
        logic       wake;
        logic       pready;
        logic       pslverr;
        logic [31:0] prdata;
    } pwo_state_t;

    // Whole state of the dead-time unit
    typedef struct packed {
        logic [1:0][12:0] cnt;
        logic [1:0]       drive;
    } pwo_dt_state_t;
endpackage

// file: logic/pwo_dt_if.sv
// Link between the override logic and the dead-time unit.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface pwo_dt_if;
    logic [1:0]        req;
    logic              comp;
    pwo_pkg::pwo_time_t dead;
    logic [1:0]        drive;
    // Requesting side and delaying side
    modport gen (output req, output comp, output dead, input drive);
    modport dt  (input req, input comp, input dead, output drive);
endinterface
`default_nettype wire

// file: logic/pwo_deadtime.sv
// Dead-time unit: delays rising requests, passes falling ones at once.
// Assumes requests come from flops on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pwo_deadtime
(
    // Clock and reset
    input  wire logic CLK_IN,
    input  wire logic NRST_IN,
    // Request side
    pwo_dt_if.dt      dt
);
    import pwo_pkg::*;

    pwo_dt_state_t d_r;
    pwo_dt_state_t d_nxt;

    // Each side waits the dead time before it may rise
    always_comb
    begin
        d_nxt = d_r;
        for (int i = 0; i < 2; i++)
        begin
            if (!dt.req[i])
            begin
                d_nxt.drive[i] = 1'b0; // Turn-off is never delayed
                d_nxt.cnt[i]   = 13'h0000;
            end
            else if (!d_r.drive[i])
            begin
                // Interlock keeps a shoot-through pair apart
                if (d_r.cnt[i] >= dt.dead && !(dt.comp && d_r.drive[1 - i]))
                    d_nxt.drive[i] = 1'b1;
                else if (d_r.cnt[i] != 13'h1FFF)
                    d_nxt.cnt[i] = d_r.cnt[i] + 13'h0001;
            end
        end
        // Both sides may finish waiting together; the low side wins the tie
        if (dt.comp && d_nxt.drive == 2'b11 && d_r.drive == 2'b00)
            d_nxt.drive[1] = 1'b0;
        if (!NRST_IN)
            d_nxt = '0;
    end

    // State register
    always_ff @(posedge CLK_IN)
    begin
        d_r <= d_nxt;
    end

    assign dt.drive = d_r.drive;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    a_fall_fast: assert property (!dt.req[1] |=> !dt.drive[1])
        else $error("high side did not fall at once");
    a_no_overlap: assert property (dt.comp |-> dt.drive != 2'b11)
        else $error("both sides driven in complementary mode");
    c_dead_wait: cover property (dt.dead > 13'h0002 && $rose(dt.req[0]) ##3 !dt.drive[0]);
endmodule // pwo_deadtime
`default_nettype wire

// file: logic/pwo_top.sv
// Output override and exception logic of one PWM generator, APB slave.
// Assumes synchronous fault and limit inputs and a port block on the pins.
`timescale 1ns/1ps
`default_nettype none
`include "pwo_defines.svh"

module pwo_top
(
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        NRST_IN,
    // APB slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // Power state and external events
    input  wire logic        SLEEP_IN,
    input  wire logic        IDLE_IN,
    input  wire logic        FAULT_N_IN,
    input  wire logic        LIMIT_IN,
    // Pins
    output logic             HIGH_SIDE_OUTPUT_OUT,
    output logic             HIGH_SIDE_OE_OUT,
    output logic             LOW_SIDE_OUTPUT_OUT,
    output logic             LOW_SIDE_OE_OUT,
    output logic             WAKE_OUT
);
    import pwo_pkg::*;

    localparam logic [15:0] PER_RST = `PWO_PER_RST;

    pwo_state_t s;
    pwo_state_t s_nxt;
    pwo_dt_if   dtl ();

    logic       tick;
    logic       wrap;
    logic       lim;
    logic       trip;
    logic       pwm;
    logic       setup;
    logic       acc;
    logic [1:0] gen;
    logic [1:0] val;
    pwo_time_t  pos;
    pwo_time_t  duty_eff;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic pwo_hit(input logic [7:0] a);
        pwo_hit = (a[1:0] == 2'h0) && (a <= `PWO_ADDR_STAT);
    endfunction

    // Time fields sit at bit 3 upward, so software never shifts
    function automatic logic [31:0] pwo_tw(input pwo_time_t t);
        pwo_tw = {16'h0000, t, 3'h0};
    endfunction

    // ****************************************************************
    // Time base and generator
    // ****************************************************************
    // Idle with the halt bit set stops counting; sleep stops too
    assign tick  = s.run && !(IDLE_IN && s.halt_idle) && !SLEEP_IN;
    // Current reset cuts the period short on the comparator
    assign wrap  = (s.cnt >= s.per) || (s.crst_en && LIMIT_IN);
    // Fault and limit stay live with the counter frozen
    assign trip  = s.trip_en && !FAULT_N_IN;
    assign lim   = s.lim_en && !s.crst_en && LIMIT_IN;
    assign pos   = s.cnt - s.phase;
    // Variable phase fixes duty at half the period
    assign duty_eff = (s.mode == PWO_VPH) ? (s.per >> 1) : s.duty;
    // A cycle-limit trip ends the pulse until the next cycle
    assign pwm   = (pos < duty_eff) && !s.cut;
    assign setup = PSEL_IN && !PENABLE_IN;
    assign acc   = PSEL_IN && PENABLE_IN && s.pready;

    // Pair the generator into high and low requests
    always_comb
    begin
        unique case (s.mode)
            PWO_PUSH: gen = {pwm && !s.pp, pwm && s.pp};
            PWO_VPH:  gen = {pwm, !pwm};
            default:  gen = {pwm, !pwm};
        endcase
    end

    // Ownership chain, lowest first; pin enable acts at the pad
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            val[i] = s.fen[i] ? s.fval[i] : gen[i];
        end
        if (lim)
            val = s.limd;
        if (trip)
            val = s.tripd;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_nxt     = s;
        s_nxt.req = val; // Levels, not enables, reach pins via dead-time
        s_nxt.oe  = s.own;
        // Counter, push-pull phase and cycle-limit latch
        if (tick)
        begin
            if (wrap)
            begin
                s_nxt.cnt = 13'h0000;
                s_nxt.pp  = !s.pp;
                s_nxt.cut = 1'b0;
            end
            else
            begin
                s_nxt.cnt = s.cnt + 13'h0001;
            end
        end
        if (lim)
            s_nxt.cut = 1'b1;
        // Duty loads at the boundary, or at once when asked
        if (s.instant_duty_update_en || !s.run || (tick && wrap))
            s_nxt.duty = s.duty_sh;
        // Manual overrides: aligned to zero or taken next clock
        if (!s.run || !s.align || s.cnt == 13'h0000)
        begin
            s_nxt.fen  = s.fen_p;
            s_nxt.fval = s.fval_p;
        end
        // Wake request holds through sleep, drops on leaving it
        if (SLEEP_IN && trip)
            s_nxt.wake = 1'b1;
        else if (!SLEEP_IN)
            s_nxt.wake = 1'b0;
        // APB: answer in the first access cycle
        if (acc)
        begin
            s_nxt.pready  = 1'b0;
            s_nxt.pslverr = 1'b0;
            if (PWRITE_IN && pwo_hit(PADDR_IN))
            begin
                unique case (PADDR_IN)
                    `PWO_ADDR_TBCTL:
                    begin
                        s_nxt.run       = PWDATA_IN[`PWO_TB_RUN];
                        s_nxt.halt_idle = PWDATA_IN[`PWO_TB_HALT];
                    end
                    `PWO_ADDR_PER:   s_nxt.per     = PWDATA_IN[15:`PWO_TIME_LSB];
                    `PWO_ADDR_DUTY:  s_nxt.duty_sh = PWDATA_IN[15:`PWO_TIME_LSB];
                    `PWO_ADDR_PHASE: s_nxt.phase   = PWDATA_IN[15:`PWO_TIME_LSB];
                    `PWO_ADDR_DEAD:  s_nxt.dead    = PWDATA_IN[15:`PWO_TIME_LSB];
                    `PWO_ADDR_GEN:
                    begin
                        s_nxt.mode    = pwo_mode_t'(PWDATA_IN[`PWO_GEN_MODE+1:`PWO_GEN_MODE]);
                        s_nxt.instant_duty_update_en     = PWDATA_IN[`PWO_GEN_IUE];
                        s_nxt.lim_en  = PWDATA_IN[`PWO_GEN_LIMEN];
                        s_nxt.crst_en = PWDATA_IN[`PWO_GEN_CRST];
                        s_nxt.trip_en = PWDATA_IN[`PWO_GEN_TRIPEN];
                    end
                    `PWO_ADDR_OUT:
                    begin
                        s_nxt.own    = {PWDATA_IN[`PWO_OUT_OWNH], PWDATA_IN[`PWO_OUT_OWNL]};
                        s_nxt.fen_p  = {PWDATA_IN[`PWO_OUT_FENH], PWDATA_IN[`PWO_OUT_FENL]};
                        s_nxt.fval_p = PWDATA_IN[`PWO_OUT_FVAL+1:`PWO_OUT_FVAL];
                        s_nxt.tripd  = PWDATA_IN[`PWO_OUT_TRIPD+1:`PWO_OUT_TRIPD];
                        s_nxt.limd   = PWDATA_IN[`PWO_OUT_LIMD+1:`PWO_OUT_LIMD];
                        s_nxt.align  = PWDATA_IN[`PWO_OUT_ALIGN];
                    end
                    default: ; // Status is read only
                endcase
            end
        end
        else if (setup)
        begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !pwo_hit(PADDR_IN);
            // Reads are latched in setup; unused bits stay zero
            unique case (PADDR_IN)
                `PWO_ADDR_TBCTL: s_nxt.prdata = {16'h0000, s.run, 1'b0, s.halt_idle, 13'h0000};
                `PWO_ADDR_PER:   s_nxt.prdata = pwo_tw(s.per);
                `PWO_ADDR_DUTY:  s_nxt.prdata = pwo_tw(s.duty_sh);
                `PWO_ADDR_PHASE: s_nxt.prdata = pwo_tw(s.phase);
                `PWO_ADDR_DEAD:  s_nxt.prdata = pwo_tw(s.dead);
                `PWO_ADDR_GEN:   s_nxt.prdata = {26'h0000000, s.trip_en, s.crst_en, s.lim_en, s.instant_duty_update_en, s.mode};
                `PWO_ADDR_OUT:   s_nxt.prdata = {16'h0000, s.own, 4'h0, s.fen_p, s.fval_p,
                                                 s.tripd, s.limd, 1'b0, s.align};
                `PWO_ADDR_STAT:  s_nxt.prdata = {16'h0000, s.cnt, s.wake, lim, trip};
                default:         s_nxt.prdata = 32'h00000000;
            endcase
        end
        // Synchronous reset: defined values, pins released
        if (!NRST_IN)
        begin
            s_nxt     = '0;
            s_nxt.per = PER_RST[15:`PWO_TIME_LSB];
        end
    end

    // State register
    always_ff @(posedge CLK_IN)
    begin
        s <= s_nxt;
    end

    // ****************************************************************
    // Dead-time unit and outputs
    // ****************************************************************
    assign dtl.req  = s.req;
    assign dtl.comp = (s.mode != PWO_PUSH);
    assign dtl.dead = s.dead;

    pwo_deadtime u_dt
    (
        .CLK_IN  (CLK_IN),
        .NRST_IN (NRST_IN),
        .dt      (dtl.dt)
    );

    assign HIGH_SIDE_OUTPUT_OUT = dtl.drive[1];
    assign LOW_SIDE_OUTPUT_OUT  = dtl.drive[0];
    assign HIGH_SIDE_OE_OUT     = s.oe[1];
    assign LOW_SIDE_OE_OUT      = s.oe[0];
    assign WAKE_OUT             = s.wake;
    assign PRDATA_OUT           = s.prdata;
    assign PREADY_OUT           = s.pready;
    assign PSLVERR_OUT          = s.pslverr;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    a_reset_tristate: assert property (@(posedge CLK_IN) disable iff (1'b0)
        !NRST_IN |=> !HIGH_SIDE_OE_OUT && !LOW_SIDE_OE_OUT)
        else $error("pins driven right after reset");
    a_reset_period: assert property (@(posedge CLK_IN) disable iff (1'b0)
        !NRST_IN |=> s.per == 13'h1FFE && !s.run && s.own == 2'b00)
        else $error("register not at reset value");
    a_pin_owner: assert property (!s.own[1] |=> !HIGH_SIDE_OE_OUT)
        else $error("high pin driven while not owned");
    a_trip_wins: assert property (trip |=> s.req == $past(s.tripd))
        else $error("fault data not on requests");
    a_limit_force: assert property (lim && !trip |=> s.req == $past(s.limd))
        else $error("limit data not on requests");
    a_manual_value: assert property (s.fen == 2'b11 && !lim && !trip |=> s.req == $past(s.fval))
        else $error("manual value not on requests");
    a_align_hold: assert property (s.run && s.align && s.cnt != 13'h0000 |=> s.fen == $past(s.fen))
        else $error("aligned override applied off zero");
    a_quick_apply: assert property (!s.align && !(acc && PWRITE_IN) ##1 1'b1 |-> s.fen == $past(s.fen_p))
        else $error("override not applied next clock");
    a_idle_freeze: assert property (IDLE_IN && s.halt_idle |=> s.cnt == $past(s.cnt))
        else $error("counter moved in halted idle");
    a_instant_duty: assert property (s.instant_duty_update_en |=> s.duty == $past(s.duty_sh))
        else $error("duty not taken at once");
    a_crst_wrap: assert property (tick && s.crst_en && LIMIT_IN |=> s.cnt == 13'h0000)
        else $error("current reset did not clear counter");
    a_sleep_wake: assert property (SLEEP_IN && trip |=> WAKE_OUT)
        else $error("no wake on fault in sleep");
    a_read_zero: assert property (PREADY_OUT && PADDR_IN == `PWO_ADDR_PER |-> PRDATA_OUT[2:0] == 3'h0)
        else $error("unused period bits not zero");

    c_trip_over_limit: cover property (lim && trip ##1 s.req == s.tripd);
    c_push_pull: cover property (s.mode == PWO_PUSH && tick && wrap ##1 s.pp);
    c_wake: cover property (SLEEP_IN ##1 WAKE_OUT);
    c_apb_write: cover property (acc && PWRITE_IN && PADDR_IN == `PWO_ADDR_OUT);
endmodule // pwo_top
`default_nettype wire

// file: sim/pwo_stage_model.sv
// Power stage model: two switches on the pins plus fault and limit comparators.
// Assumes the bench commands the comparators and reads the shoot-through count.
`timescale 1ns/1ps
`default_nettype none
module pwo_stage_model
(
    // Gate drive from the block, and the bench clock
    input  wire logic high_in,
    input  wire logic high_oe_in,
    input  wire logic low_in,
    input  wire logic low_oe_in,
    input  wire logic clk_in,
    // Comparator commands from the bench
    input  wire logic fault_cmd_in,
    input  wire logic limit_cmd_in,
    // Comparator outputs and the shoot-through count
    output logic      fault_n_out,
    output logic      limit_out,
    output int        shoot_out
);
    // Comparators change only on the bench's clocked commands
    assign fault_n_out = !fault_cmd_in;
    assign limit_out   = limit_cmd_in;
    // Both switches on shorts the rail, so count every such cycle
    initial shoot_out = 0;
    always @(posedge clk_in)
        if (high_in && high_oe_in && low_in && low_oe_in)
            shoot_out <= shoot_out + 1;
endmodule // pwo_stage_model
`default_nettype wire

// file: sim/pwm_output_override_exceptions_test.sv
// Self-checking bench for the override block: APB tasks and pin checks.
// Assumes the stage model on the pins and no wait states beyond PREADY.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_override_exceptions_test;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, sleep = 0, idle = 0, fcmd = 0, lcmd = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, rd2;
    logic pready, perr, hi, hoe, lo, loe, wake, fault_n, limit;
    int failures = 0, n_tests = 0, shoot;

    // ****************************************************************
    // Clock, design and stage
    // ****************************************************************
    always #2.5 clk = ~clk;
    pwo_top uut (.CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(perr), .SLEEP_IN(sleep), .IDLE_IN(idle), .FAULT_N_IN(fault_n),
        .LIMIT_IN(limit), .HIGH_SIDE_OUTPUT_OUT(hi), .HIGH_SIDE_OE_OUT(hoe),
        .LOW_SIDE_OUTPUT_OUT(lo), .LOW_SIDE_OE_OUT(loe), .WAKE_OUT(wake));
    pwo_stage_model stage (.high_in(hi), .high_oe_in(hoe), .low_in(lo), .low_oe_in(loe),
        .clk_in(clk), .fault_cmd_in(fcmd), .limit_cmd_in(lcmd), .fault_n_out(fault_n),
        .limit_out(limit), .shoot_out(shoot));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; holds the request until PREADY is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        // Ready, read data and error are taken at the rising edge only
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            failures++;
            summarize();
        end
        r = prdata;
        psel <= 0;
        pen <= 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd);
    endtask

    // Pin levels after a fixed number of cycles, sampled mid-cycle
    task automatic pins(input int n, input logic [1:0] e);
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk({30'h0, hi, lo}, {30'h0, e}, "pins");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        #400000 failures++;
        summarize();
    end

    initial
    begin
        repeat (3) @(negedge clk);
        chk({30'h0, hoe, loe}, 32'h0, "oe in reset");
        repeat (2) @(posedge clk);
        nrst <= 1;
        apb(0, 8'h04, 0, rd); chk(rd, 32'h0000FFF0, "period reset");
        apb(0, 8'h18, 0, rd); chk(rd, 32'h0, "outctl reset");
        apb(0, 8'h20, 0, rd); chk({rd[30:0], perr}, 32'h1, "unmapped");
        wr(8'h10, 32'hFFFFFFFF);
        apb(0, 8'h10, 0, rd); chk(rd, 32'h0000FFF8, "dead bits");
        wr(8'h10, 32'h40); // Eight clocks of dead time
        wr(8'h18, 32'h4000);
        pins(2, 2'b01); // Stopped generator is low, so the low side is on
        chk({30'h0, hoe, loe}, 32'h1, "low owned");
        // Manual force with the time base stopped: high waits out dead time
        wr(8'h18, 32'hC380);
        pins(3, 2'b00);
        pins(10, 2'b10);
        wr(8'h18, 32'hC340);
        pins(3, 2'b00);
        pins(10, 2'b01);
        // No override: generator low, low side on
        wr(8'h18, 32'hC000);
        pins(14, 2'b01);
        // Limit forcing and its priorities over manual and under fault
        wr(8'h14, 32'h28);
        wr(8'h18, 32'hC358);
        @(posedge clk) lcmd <= 1;
        pins(14, 2'b10);
        @(posedge clk) fcmd <= 1;
        pins(14, 2'b01);
        @(posedge clk) fcmd <= 0;
        pins(14, 2'b10);
        @(posedge clk) lcmd <= 0;
        // Outputs released before sleep; a fault must still wake
        wr(8'h18, 32'h0);
        @(posedge clk) sleep <= 1;
        @(posedge clk) fcmd <= 1;
        pins(4, 2'b00);
        chk({31'h0, wake}, 32'h1, "wake");
        @(posedge clk) sleep <= 0;
        pins(3, 2'b00);
        chk({30'h0, wake, hoe}, 32'h0, "wake clear");
        @(posedge clk) fcmd <= 0;
        // Halted in idle: counter frozen, fault still forces pins
        wr(8'h18, 32'hC020);
        wr(8'h00, 32'hA000);
        @(posedge clk) idle <= 1;
        apb(0, 8'h1C, 0, rd);
        apb(0, 8'h1C, 0, rd2);
        chk(rd2 & 32'hFFF8, rd & 32'hFFF8, "counter frozen");
        @(posedge clk) fcmd <= 1;
        pins(14, 2'b10);
        @(posedge clk) fcmd <= 0;
        wr(8'h00, 32'h8000);
        apb(0, 8'h1C, 0, rd);
        apb(0, 8'h1C, 0, rd2);
        chk({31'h0, (rd2 & 32'hFFF8) != (rd & 32'hFFF8)}, 32'h1, "counter runs");
        @(posedge clk) idle <= 0;
        // Running base: unaligned applies at once, aligned waits for zero
        wr(8'h18, 32'hC340);
        pins(14, 2'b01);
        wr(8'h18, 32'hC381);
        pins(20, 2'b01);
        for (int i = 0; i < 9000 && hi !== 1'b1; i++)
            @(negedge clk);
        chk({30'h0, hi, lo}, 32'h2, "aligned force");
        chk(shoot, 0, "shoot through");
        summarize();
    end
endmodule // pwm_output_override_exceptions_test
`default_nettype wire
